// *** tciu_channel.sv ***
// timer channel with prescaler, modes, output bank and axi4-lite registers
`timescale 1ns/1ps
module tciu_channel (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [tciu_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// axi4-lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read address
	input wire logic [tciu_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// axi4-lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// timer pins
	input wire logic timer_input_pin,
	output logic [3:0] timer_output_pin,
	// interrupt
	output logic channel_timer_interrupt
);
	import tciu_pkg::*;

	// bus state
	logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
	logic [ADDR_W-1:0] waddr_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic [3:0] wstrb_ff;
	logic [1:0] bresp_ff, rresp_ff;

	// registers
	logic [15:0] prescale_ff, mode_ff, cmp_ff;
	logic [3:0] level_ff, oe_ff;
	logic irq_flag_ff, irq_mask_ff, enabled_ff, supply_ff;

	// counter engine, pin synchroniser and its edge memory
	tciu_state_type state_ff, nxt_state;
	logic [15:0] counter_ff, nxt_counter;
	logic timer_evt, cap_evt, pin_s1_ff, pin_s2_ff, pin_prev_ff;

	// decoded wires
	logic wr_fire, wr_ok, rd_ok, start_req, stop_req, flag_clr;
	logic sel_prescale, sel_mode, sel_cmp, sel_level, sel_oe, sel_flag, sel_mask, sel_supply;
	logic [7:0] wr_word, rd_word;
	logic [15:0] level_wr, oe_wr;
	logic [3:0] nxt_level;
	logic [31:0] rd_value;
	tciu_mode_type mode;
	logic mode_low, count_up, start_irq, restart_ok;
	logic tick_a, tick_b, tick_c, tick_d, op_tick, cnt_tick;
	logic pin_rise, pin_fall, pin_edge;
	logic [1:0] clock_pick, edge_pick;

	// handshake readies: one item of each kind held at a time
	assign awready = !aw_held_ff;
	assign wready = !w_held_ff;
	assign arready = !rvalid_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;

	// write address and data are latched in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			waddr_ff <= '0;
		end else if (wr_fire) begin
			aw_held_ff <= 1'b0;
		end else if (awvalid && !aw_held_ff) begin
			aw_held_ff <= 1'b1;
			waddr_ff <= awaddr;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_ff <= 1'b0;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
		end else if (wr_fire) begin
			w_held_ff <= 1'b0;
		end else if (wvalid && !w_held_ff) begin
			w_held_ff <= 1'b1;
			wdata_ff <= wdata;
			wstrb_ff <= wstrb;
		end
	end

	// the write is done once both halves are in and no response waits
	assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
	assign wr_word = word_addr(waddr_ff);
	assign wr_ok = addr_mapped(wr_word);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// write selects
	assign sel_prescale = wr_fire && (wr_word == OFF_PRESCALE);
	assign sel_mode = wr_fire && (wr_word == OFF_MODE);
	assign sel_cmp = wr_fire && (wr_word == OFF_CMP);
	assign sel_level = wr_fire && (wr_word == OFF_LEVEL);
	assign sel_oe = wr_fire && (wr_word == OFF_OE);
	assign sel_flag = wr_fire && (wr_word == OFF_IRQ_FLAG) && wstrb_ff[0];
	assign sel_mask = wr_fire && (wr_word == OFF_IRQ_MASK) && wstrb_ff[0];
	assign sel_supply = wr_fire && (wr_word == OFF_SUPPLY) && wstrb_ff[0];
	assign start_req = wr_fire && (wr_word == OFF_START) && wstrb_ff[0]
		&& wdata_ff[CH_BIT];
	assign stop_req = wr_fire && (wr_word == OFF_STOP) && wstrb_ff[0] && wdata_ff[CH_BIT];
	assign flag_clr = sel_flag && wdata_ff[IRQ_BIT];

	// read decode; unmapped words answer zero with slverr
	assign rd_word = word_addr(araddr);
	always_comb begin
		rd_value = 32'h0000_0000;
		rd_ok = addr_mapped(rd_word);
		if (rd_word == OFF_PRESCALE) begin
			rd_value[15:0] = prescale_ff;
		end else if (rd_word == OFF_MODE) begin
			rd_value[15:0] = mode_ff;
		end else if (rd_word == OFF_CMP) begin
			rd_value[15:0] = cmp_ff;
		end else if (rd_word == OFF_LEVEL) begin
			rd_value[3:0] = level_ff;
		end else if (rd_word == OFF_OE) begin
			rd_value[3:0] = oe_ff;
		end else if (rd_word == OFF_IRQ_FLAG) begin
			rd_value[IRQ_BIT] = irq_flag_ff;
		end else if (rd_word == OFF_IRQ_MASK) begin
			rd_value[IRQ_BIT] = irq_mask_ff;
		end else if (rd_word == OFF_STATUS) begin
			rd_value[CH_BIT] = enabled_ff;
		end else if (rd_word == OFF_COUNTER) begin
			rd_value[15:0] = counter_ff;
		end else if (rd_word == OFF_SUPPLY) begin
			rd_value[SUPPLY_BIT] = supply_ff;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= RESP_OKAY;
		end else if (arvalid && !rvalid_ff) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_value;
			rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// configuration registers; reserved bits stay zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prescale_ff <= PRESCALE_RST;
			mode_ff <= MODE_RST;
			supply_ff <= SUPPLY_RST;
			oe_ff <= OE_RST;
			level_ff <= LEVEL_RST;
		end else begin
			level_ff <= nxt_level;
			if (sel_prescale) begin
				prescale_ff <= apply_strb(prescale_ff, wdata_ff, wstrb_ff) & PRESCALE_WMASK;
			end
			if (sel_mode) begin
				mode_ff <= apply_strb(mode_ff, wdata_ff, wstrb_ff) & MODE_WMASK;
			end
			if (sel_supply) begin
				supply_ff <= wdata_ff[SUPPLY_BIT];
			end
			if (sel_oe) begin
				oe_ff <= oe_wr[3:0];
			end
		end
	end

	// compare value; a capture overrides a software write in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmp_ff <= CMP_RST;
		end else if (cap_evt) begin
			cmp_ff <= counter_ff;
		end else if (sel_cmp) begin
			cmp_ff <= apply_strb(cmp_ff, wdata_ff, wstrb_ff);
		end
	end

	// output bank: software cannot write enabled bits, the timer toggles only bit 0 when it is enabled, the rest belong to software
	assign level_wr = apply_strb({12'h000, level_ff}, wdata_ff, wstrb_ff);
	assign oe_wr = apply_strb({12'h000, oe_ff}, wdata_ff, wstrb_ff);
	assign nxt_level = (sel_level ? ((level_wr[3:0] & ~oe_ff) | (level_ff & oe_ff))
		: level_ff) ^ {3'b000, timer_evt && oe_ff[CH_BIT]};

	assign timer_output_pin = level_ff;

	// interrupt flag (event beats clear) and enabled status (start beats stop)
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_flag_ff <= IRQ_FLAG_RST;
			irq_mask_ff <= IRQ_MASK_RST;
			enabled_ff <= 1'b0;
		end else begin
			irq_flag_ff <= timer_evt || (irq_flag_ff && !flag_clr);
			enabled_ff <= start_req || (enabled_ff && !stop_req);
			if (sel_mask) begin
				irq_mask_ff <= wdata_ff[IRQ_BIT];
			end
		end
	end

	assign channel_timer_interrupt = irq_flag_ff && !irq_mask_ff;

	// prescaler runs only while the unit clock supply is on
	tciu_prescaler u_prescaler (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(supply_ff),
		.div_a(prescale_ff[DIV_A_LSB +: 4]),
		.div_b(prescale_ff[DIV_B_LSB +: 4]),
		.div_c(prescale_ff[DIV_C_LSB +: 2]),
		.div_d(prescale_ff[DIV_D_LSB +: 2]),
		.tick_a(tick_a),
		.tick_b(tick_b),
		.tick_c(tick_c),
		.tick_d(tick_d)
	);

	// two flops before any logic looks at the pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_ff <= 1'b0;
			pin_s2_ff <= 1'b0;
			pin_prev_ff <= 1'b0;
		end else begin
			pin_s1_ff <= timer_input_pin;
			pin_s2_ff <= pin_s1_ff;
			pin_prev_ff <= pin_s2_ff;
		end
	end

	// valid edge: 00 falling, 01 rising, else both
	assign edge_pick = mode_ff[EDGE_PICK_LSB +: 2];
	assign pin_rise = pin_s2_ff && !pin_prev_ff;
	assign pin_fall = !pin_s2_ff && pin_prev_ff;
	assign pin_edge = supply_ff && ((edge_pick == 2'b00) ? pin_fall
		: (edge_pick == 2'b01) ? pin_rise : (pin_rise || pin_fall));

	// note the crossed middle codes of the clock pick
	assign clock_pick = mode_ff[CLK_PICK_LSB +: 2];
	assign op_tick = (clock_pick == 2'b00) ? tick_a
		: (clock_pick == 2'b01) ? tick_c
		: (clock_pick == 2'b10) ? tick_b : tick_d;
	assign cnt_tick = mode_ff[COUNT_SRC_BIT] ? pin_edge : op_tick;

	// mode decoding and its per-mode options
	assign mode = decode_mode(mode_ff[MODE_LSB +: 4]);
	assign mode_low = mode_ff[MODE_LSB];
	assign count_up = (mode == MODE_CAPTURE) || (mode == MODE_CAPONE);
	assign start_irq = ((mode == MODE_INTERVAL) || (mode == MODE_CAPTURE))
		&& mode_low;
	assign restart_ok = (mode == MODE_INTERVAL) || (mode == MODE_CAPTURE)
		|| (mode == MODE_EVENT) || ((mode == MODE_ONECOUNT) && mode_low);

	// counter engine: armed waits for the first count tick, then counts
	always_comb begin
		nxt_state = state_ff;
		nxt_counter = counter_ff;
		timer_evt = 1'b0;
		cap_evt = 1'b0;
		if ((stop_req && !start_req) || (mode == MODE_BAD)) begin
			nxt_state = ST_IDLE;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (start_req) begin
						nxt_state = ST_ARMED;
					end
				end
				ST_ARMED: begin
					if (cnt_tick) begin
						nxt_state = ST_COUNT;
						nxt_counter = count_up ? COUNTER_RST : cmp_ff;
						timer_evt = start_irq;
					end
				end
				ST_COUNT: begin
					if (start_req && restart_ok) begin
						nxt_state = ST_ARMED;
					end else if (count_up && pin_edge) begin
						cap_evt = 1'b1;
						timer_evt = 1'b1;
						nxt_counter = COUNTER_RST;
						if (mode == MODE_CAPONE) begin
							nxt_state = ST_IDLE;
						end
					end else if (cnt_tick && count_up) begin
						nxt_counter = counter_ff + 16'h0001;
					end else if (cnt_tick && (counter_ff == 16'h0000)) begin
						timer_evt = 1'b1;
						nxt_counter = cmp_ff;
						if (mode == MODE_ONECOUNT) begin
							nxt_state = ST_IDLE;
						end
					end else if (cnt_tick) begin
						nxt_counter = counter_ff - 16'h0001;
					end
				end
				default: begin
					nxt_state = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= ST_IDLE;
			counter_ff <= COUNTER_RST;
		end else begin
			state_ff <= nxt_state;
			counter_ff <= nxt_counter;
		end
	end
endmodule

// *** tciu_pkg.sv ***
// package: register map, field layout, modes and states of the timer channel
package tciu_pkg;
	// bus geometry and prescaler counter width
	localparam int ADDR_W = 8;
	localparam int PRE_CNT_W = 15;

	// register byte offsets
	localparam logic [7:0] OFF_PRESCALE = 8'h00;
	localparam logic [7:0] OFF_MODE = 8'h04;
	localparam logic [7:0] OFF_CMP = 8'h08;
	localparam logic [7:0] OFF_LEVEL = 8'h0c;
	localparam logic [7:0] OFF_OE = 8'h10;
	localparam logic [7:0] OFF_IRQ_FLAG = 8'h14;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
	localparam logic [7:0] OFF_START = 8'h1c;
	localparam logic [7:0] OFF_STATUS = 8'h20;
	localparam logic [7:0] OFF_COUNTER = 8'h24;
	localparam logic [7:0] OFF_SUPPLY = 8'h28;
	localparam logic [7:0] OFF_STOP = 8'h2c;

	// writable bits and values after reset
	localparam logic [15:0] PRESCALE_WMASK = 16'h33ff;
	localparam logic [15:0] MODE_WMASK = 16'hd7cf;
	localparam logic [15:0] PRESCALE_RST = 16'h0000;
	localparam logic [15:0] MODE_RST = 16'h0000;
	localparam logic [15:0] CMP_RST = 16'h0000;
	localparam logic [15:0] COUNTER_RST = 16'h0000;
	localparam logic [3:0] LEVEL_RST = 4'h0;
	localparam logic [3:0] OE_RST = 4'h0;
	localparam logic IRQ_FLAG_RST = 1'b0;
	localparam logic IRQ_MASK_RST = 1'b1;
	localparam logic SUPPLY_RST = 1'b0;

	// field positions
	localparam int DIV_A_LSB = 0;
	localparam int DIV_B_LSB = 4;
	localparam int DIV_C_LSB = 8;
	localparam int DIV_D_LSB = 12;
	localparam int CLK_PICK_LSB = 14;
	localparam int COUNT_SRC_BIT = 12;
	localparam int EDGE_PICK_LSB = 6;
	localparam int MODE_LSB = 0;
	localparam int IRQ_BIT = 4;
	localparam int CH_BIT = 0;
	localparam int SUPPLY_BIT = 0;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		MODE_INTERVAL,
		MODE_CAPTURE,
		MODE_EVENT,
		MODE_ONECOUNT,
		MODE_CAPONE,
		MODE_BAD
	} tciu_mode_type;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARMED,
		ST_COUNT
	} tciu_state_type;

	// mode code to mode; low bit matters only where it is fixed
	function automatic tciu_mode_type decode_mode(input logic [3:0] md);
		if (md[3:1] == 3'b000) begin
			decode_mode = MODE_INTERVAL;
		end else if (md[3:1] == 3'b010) begin
			decode_mode = MODE_CAPTURE;
		end else if (md == 4'b0110) begin
			decode_mode = MODE_EVENT;
		end else if (md[3:1] == 3'b100) begin
			decode_mode = MODE_ONECOUNT;
		end else if (md == 4'b1100) begin
			decode_mode = MODE_CAPONE;
		end else begin
			decode_mode = MODE_BAD;
		end
	endfunction

	// word address, byte lanes dropped
	function automatic logic [7:0] word_addr(input logic [7:0] a);
		word_addr = {a[7:2], 2'b00};
	endfunction

	function automatic logic addr_mapped(input logic [7:0] w);
		addr_mapped = (w <= OFF_STOP);
	endfunction

	// merge the two low byte lanes of a write into a 16-bit register
	function automatic logic [15:0] apply_strb(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] strb);
		apply_strb = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
	endfunction
endpackage

// *** tciu_prescaler.sv ***
// shared prescaler: four divide-by-power-of-two tick strobes
`timescale 1ns/1ps
module tciu_prescaler (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// supply gate and divider fields
	input wire logic run,
	input wire logic [3:0] div_a,
	input wire logic [3:0] div_b,
	input wire logic [1:0] div_c,
	input wire logic [1:0] div_d,
	// one-cycle tick strobes
	output logic tick_a,
	output logic tick_b,
	output logic tick_c,
	output logic tick_d
);
	import tciu_pkg::*;

	logic [PRE_CNT_W-1:0] count_ff;

	// low n bits all ones: once every 2**n cycles, every cycle for n = 0
	function automatic logic at_rollover(input logic [PRE_CNT_W-1:0] cnt,
		input logic [3:0] n);
		logic [PRE_CNT_W-1:0] mask;
		mask = (PRE_CNT_W'(1) << n) - PRE_CNT_W'(1);
		at_rollover = &(cnt | ~mask);
	endfunction

	// free-running divider; frozen while the supply is off
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_ff <= '0;
		end else if (run) begin
			count_ff <= count_ff + PRE_CNT_W'(1);
		end
	end

	// ticks share one counter so all four stay phase aligned
	assign tick_a = run && at_rollover(count_ff, div_a);
	assign tick_b = run && at_rollover(count_ff, div_b);
	assign tick_c = run && at_rollover(count_ff, {2'b00, div_c});
	assign tick_d = run && at_rollover(count_ff, {2'b00, div_d});
endmodule

// *** tciu_channel_sva.sv ***
// checker: bus handshakes and output relations of the timer channel
`timescale 1ns/1ps
module tciu_channel_sva import tciu_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write channels
	input wire logic [tciu_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	// read channels
	input wire logic [tciu_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	// pins and interrupt
	input wire logic timer_input_pin,
	input wire logic [3:0] timer_output_pin,
	input wire logic channel_timer_interrupt
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// a write whose address and data are taken at one edge with no answer pending
	wire both_w = awvalid && awready && wvalid && wready && !bvalid;
	a_bvalid_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped early");
	a_rvalid_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read answer dropped early");
	a_arready_tracks: assert property (arready == !rvalid)
		else $error("arready not the inverse of rvalid");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	a_write_answer: assert property (both_w |-> ##2 bvalid)
		else $error("write answer late");
	a_aw_held: assert property (awvalid && awready && !(wvalid && wready) |=> !awready)
		else $error("second address taken while one held");
	a_bad_read_err: assert property (arvalid && arready && araddr > 8'h2f |=>
		rresp == RESP_SLVERR && rdata == 32'h0) else $error("unmapped read not refused");
	a_bad_write_err: assert property (both_w && awaddr > 8'h2f |-> ##2 bresp == RESP_SLVERR)
		else $error("unmapped write not refused");
	// reset must be seen even though the others are disabled during it
	a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
		timer_output_pin == 4'h0 && !channel_timer_interrupt && !bvalid && !rvalid)
		else $error("outputs not cleared");
	cover property ($rose(channel_timer_interrupt));
	cover property (bvalid && bready && bresp == RESP_SLVERR);
	cover property (rvalid && rready && rresp == RESP_OKAY);
endmodule
bind tciu_channel tciu_channel_sva chk (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
	.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
	.rresp, .rvalid, .rready, .timer_input_pin, .timer_output_pin, .channel_timer_interrupt);

// *** tciu_channel_tb_top.sv ***
// self-checking bench for the timer channel over its register bus
`timescale 1ns/1ps
module tciu_channel_tb_top;
	import tciu_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic bready = 1'b1, rready = 1'b1, timer_input_pin = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd, rd0;
	logic [3:0] wstrb = 4'hf, timer_output_pin;
	logic [1:0] bresp, rresp, rs;
	logic awready, wready, bvalid, arready, rvalid, channel_timer_interrupt;
	int failures = 0, comparisons = 0, cyc = 0, t1, t2;
	logic [15:0] pre_t [5] = '{16'h0000, 16'h0002, 16'h0010, 16'h0200, 16'h1000};
	logic [15:0] mod_t [5] = '{16'h0000, 16'h0000, 16'h8000, 16'h4000, 16'hc000};
	logic [15:0] cmp_t [5] = '{16'h0009, 16'h0001, 16'h0003, 16'h0001, 16'h0004};
	int per_t [5] = '{10, 8, 8, 8, 10};
	logic [15:0] smod_t [7] = '{16'h0, 16'h1, 16'h5, 16'h4, 16'h1006, 16'hc, 16'he};
	logic [31:0] sflag_t [7] = '{32'h0, 32'h10, 32'h10, 32'h0, 32'h0, 32'h0, 32'h0};
	int dir_t [7] = '{1, 1, 2, 2, 0, 2, 3};
	always #50 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 1;
	tciu_channel dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .timer_input_pin, .timer_output_pin, .channel_timer_interrupt);
	// verdict and end of run
	task automatic results();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic give_up(input string nm);
		failures++;
		$display("BAD %s expected answer seen none", nm);
		results();
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	// one write; each channel released at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b0;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1 && bready === 1'b1) break;
			if (bvalid === 1'b1) bready <= 1'b1;
		end
		rs = bresp;
		if (n == 40) give_up("bvalid");
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b0;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1 && rready === 1'b1) break;
			if (rvalid === 1'b1) rready <= 1'b1;
		end
		d = rdata;
		rs = rresp;
		if (n == 40) give_up("rvalid");
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		rd_reg(a, rd);
		chk(nm, e, rd);
	endtask
	// cycle of the next rising interrupt edge
	task automatic wait_rise(output int t);
		int n;
		n = 0;
		while (channel_timer_interrupt !== 1'b0 && n < 300) begin
			@(posedge aclk);
			n++;
		end
		while (channel_timer_interrupt !== 1'b1 && n < 300) begin
			@(posedge aclk);
			n++;
		end
		t = cyc;
		if (n >= 300) give_up("interrupt");
	endtask
	// stop, clear the flag, then start with a new mode
	task automatic restart(input logic [15:0] m, input logic [15:0] c);
		wr(OFF_STOP, 32'h1);
		wr(OFF_CMP, {16'h0, c});
		wr(OFF_MODE, {16'h0, m});
		wr(OFF_IRQ_FLAG, 32'h10);
		wr(OFF_START, 32'h1);
	endtask
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk("mask", OFF_IRQ_MASK, 32'h10);
		rchk("flag", OFF_IRQ_FLAG, 32'h0);
		rchk("supply", OFF_SUPPLY, 32'h0);
		rchk("start", OFF_START, 32'h0);
		rchk("unmapped rdata", 8'h30, 32'h0);
		chk("unmapped rresp", RESP_SLVERR, rs);
		wr(8'h40, 32'h1);
		chk("unmapped bresp", RESP_SLVERR, rs);
		wr(OFF_CMP, 32'ha5c3);
		rchk("cmp", OFF_CMP, 32'ha5c3);
		wr(OFF_LEVEL, 32'h5);
		chk("pin", 4'h5, timer_output_pin);
		wr(OFF_OE, 32'h1);
		wr(OFF_LEVEL, 32'h0);
		chk("pin held", 4'h1, timer_output_pin);
		wr(OFF_OE, 32'h0);
		// with the supply stopped nothing may count
		restart(16'h0, 16'h2);
		repeat (20) @(posedge aclk);
		rchk("flag unsupplied", OFF_IRQ_FLAG, 32'h0);
		rchk("status", OFF_STATUS, 32'h1);
		wr(OFF_SUPPLY, 32'h1);
		wr(OFF_IRQ_MASK, 32'h0);
		// rise to rise spacing for each divider and clock pick
		for (int i = 0; i < 5; i++) begin
			wr(OFF_STOP, 32'h1);
			wr(OFF_PRESCALE, {16'h0, pre_t[i]});
			restart(mod_t[i], cmp_t[i]);
			wait_rise(t1);
			wr(OFF_IRQ_FLAG, 32'h10);
			wait_rise(t2);
			chk("period", per_t[i], 32'(t2 - t1));
		end
		wr(OFF_IRQ_MASK, 32'h10);
		rchk("flag masked", OFF_IRQ_FLAG, 32'h10);
		chk("irq masked", 1'b0, channel_timer_interrupt);
		wr(OFF_IRQ_MASK, 32'h0);
		chk("irq unmasked", 1'b1, channel_timer_interrupt);
		wr(OFF_PRESCALE, 32'h0);
		// start behaviour of every mode kind except the one-count mode, direction of each except one-count and event
		for (int i = 0; i < 7; i++) begin
			restart(smod_t[i], 16'hffff);
			repeat (6) @(posedge aclk);
			rchk("start flag", OFF_IRQ_FLAG, sflag_t[i]);
			rd_reg(OFF_COUNTER, rd);
			if (dir_t[i] == 1) chk("down", 1'b1, rd[15:0] > 16'hff00 && rd[15:0] < 16'hffff);
			if (dir_t[i] == 2) chk("up", 1'b1, rd[15:0] > 16'h0 && rd[15:0] < 16'h0100);
			if (dir_t[i] == 3) begin
				rd0 = rd;
				repeat (4) @(posedge aclk);
				rd_reg(OFF_COUNTER, rd);
				chk("idle", rd0, rd);
			end
		end
		// a falling pin edge captures the up count and raises the flag
		restart(16'h0004, 16'h0000);
		repeat (10) @(posedge aclk);
		timer_input_pin <= 1'b0;
		repeat (8) @(posedge aclk);
		timer_input_pin <= 1'b1;
		rchk("capture flag", OFF_IRQ_FLAG, 32'h10);
		rd_reg(OFF_CMP, rd);
		chk("captured", 1'b1, rd[15:0] > 16'h0008 && rd[15:0] < 16'h0014);
		// falling pin edges drive the event count
		restart(16'h1006, 16'h3);
		for (int i = 0; i < 16; i++) begin
			repeat (3) @(posedge aclk);
			timer_input_pin <= ~timer_input_pin;
		end
		repeat (6) @(posedge aclk);
		rchk("event flag", OFF_IRQ_FLAG, 32'h10);
		// second start while counting: ignored or restarts
		for (int m = 0; m < 2; m++) begin
			restart(16'h8 | 16'(m), 16'd40);
			repeat (15) @(posedge aclk);
			wr(OFF_START, 32'h1);
			repeat (30) @(posedge aclk);
			rchk("retrigger", OFF_IRQ_FLAG, m ? 32'h0 : 32'h10);
		end
		results();
	end
endmodule
